// File: hw/ttd_divider.sv
/*
   Free-running shared divider: one counter per source clock, each
   advanced by a one-cycle enable pulse.
   Assumes the enables come from edge detection of synchronised clocks.
   Nothing but reset clears the counters.
*/
`timescale 1ns/1ps
module ttd_divider #(
   parameter int FC_W = ttd_pkg::TTD_FC_W,
   parameter int FS_W = ttd_pkg::TTD_FS_W
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic fc_en_i,
   input wire logic fs_en_i,
   output logic [FC_W-1:0] fc_cnt_o,
   output logic [FS_W-1:0] fs_cnt_o
);

   typedef struct packed {
      logic [FC_W-1:0] fc_cnt;
      logic [FS_W-1:0] fs_cnt;
   } ttd_div_state_t;

   ttd_div_state_t st_reg;
   ttd_div_state_t st_next;

   // counters wrap; no software path clears them
   always_comb
   begin
      st_next = st_reg;
      if (fc_en_i)
         st_next.fc_cnt = st_reg.fc_cnt + {{(FC_W-1){1'b0}}, 1'b1};
      if (fs_en_i)
         st_next.fs_cnt = st_reg.fs_cnt + {{(FS_W-1){1'b0}}, 1'b1};
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end

   assign fc_cnt_o = st_reg.fc_cnt;
   assign fs_cnt_o = st_reg.fs_cnt;

endmodule

// File: hw/ttd_sync.sv
/*
   Two-flop synchroniser for a bus of independent levels.
   Assumes each bit is a slow level or a clock much slower than clk_i.
*/
`timescale 1ns/1ps
module ttd_sync #(
   parameter int W = 2
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);

   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] sync;
   } ttd_sync_state_t;

   ttd_sync_state_t st_reg;
   ttd_sync_state_t st_next;

   // first stage feeds only the second
   always_comb
   begin
      st_next = st_reg;
      st_next.meta = d_i;
      st_next.sync = st_reg.meta;
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end

   assign q_o = st_reg.sync;

endmodule

// File: hw/ttd_top.sv
/*
   Tick and tone divider: periodic tick interrupt from a selectable tap
   of the shared divider, and an active-low square wave on the tone pin
   for a piezo buzzer. Registers over APB, one level interrupt.
   Assumes 250 MHz CLOCK_I, the 16 MHz and 32.768 kHz clocks arriving
   as pins, and an APB master on CLOCK_I.
*/
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module ttd_top #(
   parameter int FC_W = ttd_pkg::TTD_FC_W,
   parameter int FS_W = ttd_pkg::TTD_FS_W
) (
   input wire logic CLOCK_I,
   input wire logic RST_N_I,
   input wire logic FC_CLK_I,
   input wire logic FS_CLK_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [7:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   output logic IRQ_O,
   output logic TONE_N_O
);

   typedef struct packed {
      logic [2:0] tick_rate_select;
      logic tick_enable;
      logic tick_live;
      logic [1:0] tone_rate_select;
      logic tone_enable;
      logic tone_live;
      logic divider_clock_source_select;
      logic slow_clock_mode;
      logic fc_d;
      logic fs_d;
      logic tick_tap_d;
      logic tone_tap_d;
      logic periodic_tick_interrupt;
      logic [ttd_pkg::TTD_EVT_W-1:0] status;
      logic [ttd_pkg::TTD_EVT_W-1:0] irq_en;
      logic tone_n;
      logic [31:0] rdata;
      logic slverr;
   } ttd_top_state_t;

   ttd_top_state_t st_reg;
   ttd_top_state_t st_next;

   logic [1:0] clk_sync;
   logic fc_en;
   logic fs_en;
   logic [FC_W-1:0] fc_cnt;
   logic [FS_W-1:0] fs_cnt;
   logic use_fs;
   logic tick_tap;
   logic tone_tap;
   logic tick_fall;
   logic tone_fall;
   logic apb_setup;
   logic apb_write;
   logic [ttd_pkg::TTD_EVT_W-1:0] evt;
   logic [ttd_pkg::TTD_EVT_W-1:0] clr;

   // tick tap: low-frequency code with no rate yields a still tap
   function automatic logic tick_tap_f(input logic [2:0] sel,
                                       input logic slow_src,
                                       input logic [FC_W-1:0] fc,
                                       input logic [FS_W-1:0] fs);
      logic tap;
      tap = fc[ttd_pkg::TTD_FC_TICK_TAP[sel]];
      if (slow_src)
      begin
         tap = fs[ttd_pkg::TTD_FS_TICK_TAP[sel]];
         if (sel == ttd_pkg::TTD_FS_TICK_NONE)
            tap = 1'b0;
      end
      return tap;
   endfunction

   function automatic logic tone_tap_f(input logic [1:0] sel,
                                       input logic slow_src,
                                       input logic [FC_W-1:0] fc,
                                       input logic [FS_W-1:0] fs);
      logic tap;
      tap = fc[ttd_pkg::TTD_FC_TONE_TAP[sel]];
      if (slow_src)
         tap = fs[ttd_pkg::TTD_FS_TONE_TAP[sel]];
      return tap;
   endfunction

   // source clocks are pins: two flops before any logic
   ttd_sync #(
      .W(2)
   ) u_sync (
      .clk_i(CLOCK_I),
      .rst_n_i(RST_N_I),
      .d_i({FS_CLK_I, FC_CLK_I}),
      .q_o(clk_sync)
   );

   // rising edges of the synchronised clocks advance the divider
   assign fc_en = clk_sync[0] & ~st_reg.fc_d;
   assign fs_en = clk_sync[1] & ~st_reg.fs_d;

   ttd_divider #(
      .FC_W(FC_W),
      .FS_W(FS_W)
   ) u_div (
      .clk_i(CLOCK_I),
      .rst_n_i(RST_N_I),
      .fc_en_i(fc_en),
      .fs_en_i(fs_en),
      .fc_cnt_o(fc_cnt),
      .fs_cnt_o(fs_cnt)
   );

   // slow mode also runs the divider from the low-frequency clock
   assign use_fs = st_reg.divider_clock_source_select
                   | st_reg.slow_clock_mode;
   assign tick_tap = tick_tap_f(st_reg.tick_rate_select, use_fs,
                                fc_cnt, fs_cnt);
   assign tone_tap = tone_tap_f(st_reg.tone_rate_select, use_fs,
                                fc_cnt, fs_cnt);

   // live gates need one settled cycle, so the write that sets the
   // rate and the enable together cannot fake an edge
   assign tick_fall = st_reg.tick_live & st_reg.tick_tap_d
                      & ~tick_tap;
   assign tone_fall = st_reg.tone_live & st_reg.tone_tap_d & ~tone_tap;

   // APB decode helpers
   assign apb_setup = PSEL_I & ~PENABLE_I;
   assign apb_write = PSEL_I & PENABLE_I & PWRITE_I;
   assign evt = {tone_fall, tick_fall};
   assign clr = (apb_write && PADDR_I == ttd_pkg::TTD_CLR_OFS)
                ? PWDATA_I[ttd_pkg::TTD_EVT_W-1:0]
                : ttd_pkg::TTD_EVT_RST;

   always_comb
   begin
      st_next = st_reg;
      st_next.fc_d = clk_sync[0];
      st_next.fs_d = clk_sync[1];
      st_next.tick_tap_d = tick_tap;
      st_next.tone_tap_d = tone_tap;
      // divider is never touched here on enable
      st_next.tick_live = st_reg.tick_enable;
      st_next.tone_live = st_reg.tone_enable;
      st_next.periodic_tick_interrupt = tick_fall;
      // set wins over a clear in the same cycle
      st_next.status = (st_reg.status & ~clr) | evt;
      // idle pin is high; enabled pin follows the tap inverted
      st_next.tone_n = ~(st_reg.tone_live & tone_tap);
      // register writes land at the access edge
      if (apb_write)
      begin
         if (PADDR_I == ttd_pkg::TTD_CTRL_OFS)
         begin
            st_next.tick_rate_select = PWDATA_I[ttd_pkg::TTD_TICK_SEL_LSB
               +: ttd_pkg::TTD_TICK_SEL_W];
            st_next.tick_enable = PWDATA_I[ttd_pkg::TTD_TICK_EN_BIT];
            st_next.tone_rate_select = PWDATA_I[ttd_pkg::TTD_TONE_SEL_LSB
               +: ttd_pkg::TTD_TONE_SEL_W];
            st_next.tone_enable = PWDATA_I[ttd_pkg::TTD_TONE_EN_BIT];
            // a disabling write kills the gate at once
            if (!PWDATA_I[ttd_pkg::TTD_TICK_EN_BIT])
               st_next.tick_live = 1'b0;
            if (!PWDATA_I[ttd_pkg::TTD_TONE_EN_BIT])
               st_next.tone_live = 1'b0;
         end
         else if (PADDR_I == ttd_pkg::TTD_CFG_OFS)
         begin
            st_next.divider_clock_source_select =
               PWDATA_I[ttd_pkg::TTD_CFG_SRC_BIT];
            st_next.slow_clock_mode = PWDATA_I[ttd_pkg::TTD_CFG_SLOW_BIT];
         end
         else if (PADDR_I == ttd_pkg::TTD_IEN_OFS)
            st_next.irq_en = PWDATA_I[ttd_pkg::TTD_EVT_W-1:0];
      end
      // read data and error are fetched in the setup cycle
      if (apb_setup)
      begin
         st_next.rdata = 32'h0000_0000;
         st_next.slverr = 1'b0;
         if (PADDR_I == ttd_pkg::TTD_CTRL_OFS)
         begin
            st_next.rdata[ttd_pkg::TTD_TICK_SEL_LSB
               +: ttd_pkg::TTD_TICK_SEL_W] = st_reg.tick_rate_select;
            st_next.rdata[ttd_pkg::TTD_TICK_EN_BIT] = st_reg.tick_enable;
            st_next.rdata[ttd_pkg::TTD_TONE_SEL_LSB
               +: ttd_pkg::TTD_TONE_SEL_W] = st_reg.tone_rate_select;
            st_next.rdata[ttd_pkg::TTD_TONE_EN_BIT] = st_reg.tone_enable;
         end
         else if (PADDR_I == ttd_pkg::TTD_CFG_OFS)
         begin
            st_next.rdata[ttd_pkg::TTD_CFG_SRC_BIT] =
               st_reg.divider_clock_source_select;
            st_next.rdata[ttd_pkg::TTD_CFG_SLOW_BIT] =
               st_reg.slow_clock_mode;
         end
         else if (PADDR_I == ttd_pkg::TTD_STAT_OFS)
            st_next.rdata[ttd_pkg::TTD_EVT_W-1:0] = st_reg.status;
         else if (PADDR_I == ttd_pkg::TTD_CLR_OFS)
            st_next.rdata = 32'h0000_0000; // write-only, reads zero
         else if (PADDR_I == ttd_pkg::TTD_IEN_OFS)
            st_next.rdata[ttd_pkg::TTD_EVT_W-1:0] = st_reg.irq_en;
         else if (PADDR_I == ttd_pkg::TTD_DIV_OFS)
            st_next.rdata[FC_W-1:0] = fc_cnt;
         else
            st_next.slverr = 1'b1;
      end
   end

   always_ff @(posedge CLOCK_I)
   begin
      if (!RST_N_I)
      begin
         st_reg <= '0;
         st_reg.tick_rate_select <= ttd_pkg::TTD_TICK_SEL_RST;
         st_reg.tone_rate_select <= ttd_pkg::TTD_TONE_SEL_RST;
         st_reg.tone_n <= 1'b1;
      end
      else
         st_reg <= st_next;
   end

   // zero-wait slave; level interrupt from enabled sticky bits
   assign PREADY_O = 1'b1;
   assign PRDATA_O = st_reg.rdata;
   assign PSLVERR_O = st_reg.slverr & PSEL_I & PENABLE_I;
   assign IRQ_O = |(st_reg.status & st_reg.irq_en);
   assign TONE_N_O = st_reg.tone_n;

   // checks
   sequence seq_ctrl_write;
      apb_write && PADDR_I == ttd_pkg::TTD_CTRL_OFS;
   endsequence

   sequence seq_tick_fall;
      st_reg.tick_live && st_reg.tick_tap_d && !tick_tap;
   endsequence

   AST_FC_TAP_CODE0: assert property (
      @(posedge CLOCK_I) disable iff (!RST_N_I)
      (!use_fs && st_reg.tick_rate_select == 3'h0)
         |-> tick_tap == fc_cnt[22])
      else $error("tick tap wrong for fast code 0");

   AST_FS_TAP_CODE1: assert property (
      @(posedge CLOCK_I) disable iff (!RST_N_I)
      (use_fs && st_reg.tick_rate_select == 3'h1)
         |-> tick_tap == fs_cnt[12])
      else $error("tick tap wrong for slow code 1");

   AST_TICK_ON_FALL: assert property (
      @(posedge CLOCK_I) disable iff (!RST_N_I)
      seq_tick_fall |=> st_reg.periodic_tick_interrupt
         && st_reg.status[ttd_pkg::TTD_EVT_TICK])
      else $error("falling tap did not raise tick");

   AST_TICK_NEEDS_EN: assert property (
      @(posedge CLOCK_I) disable iff (!RST_N_I)
      st_reg.periodic_tick_interrupt |-> $past(st_reg.tick_enable, 2))
      else $error("tick raised while disabled");

   AST_DIV_NOT_CLEARED: assert property (
      @(posedge CLOCK_I) disable iff (!RST_N_I)
      $rose(st_reg.tick_enable) && !$past(fc_en)
         |-> fc_cnt == $past(fc_cnt))
      else $error("divider disturbed by tick enable");

   AST_TONE_IDLE: assert property (
      @(posedge CLOCK_I) disable iff (!RST_N_I)
      !st_reg.tone_enable ##1 !st_reg.tone_enable |=> TONE_N_O)
      else $error("tone pin low while disabled");

   AST_TONE_FOLLOW: assert property (
      @(posedge CLOCK_I) disable iff (!RST_N_I)
      st_reg.tone_live |=> TONE_N_O == !$past(tone_tap))
      else $error("tone pin not inverse of tap");

   AST_TONE_FC_TAP: assert property (
      @(posedge CLOCK_I) disable iff (!RST_N_I)
      (!use_fs && st_reg.tone_rate_select == 2'h3)
         |-> tone_tap == fc_cnt[9])
      else $error("tone tap wrong for fast code 3");

   AST_CTRL_LAYOUT: assert property (
      @(posedge CLOCK_I) disable iff (!RST_N_I)
      seq_ctrl_write |=> st_reg.tick_rate_select == $past(PWDATA_I[2:0])
         && st_reg.tick_enable == $past(PWDATA_I[3])
         && st_reg.tone_rate_select == $past(PWDATA_I[6:5])
         && st_reg.tone_enable == $past(PWDATA_I[7]))
      else $error("control fields misplaced");

   AST_IRQ_LEVEL: assert property (
      @(posedge CLOCK_I) disable iff (!RST_N_I)
      IRQ_O == |(st_reg.status & st_reg.irq_en))
      else $error("interrupt level mismatch");

endmodule

// File: inc/ttd_pkg.sv
/*
   Shared constants of the tick and tone divider: register offsets,
   control field positions, reset values and the divider tap tables.
   Assumes the divider counts high-frequency (16 MHz) and low-frequency
   (32.768 kHz) clock edges; tap k toggles at source / 2^(k+1).
*/
package ttd_pkg;

   // register byte offsets on the APB slave
   localparam logic [7:0] TTD_CTRL_OFS = 8'h00;
   localparam logic [7:0] TTD_CFG_OFS = 8'h04;
   localparam logic [7:0] TTD_STAT_OFS = 8'h08;
   localparam logic [7:0] TTD_CLR_OFS = 8'h0C;
   localparam logic [7:0] TTD_IEN_OFS = 8'h10;
   localparam logic [7:0] TTD_DIV_OFS = 8'h14;

   // tick_tone_control field layout
   localparam int TTD_TICK_SEL_LSB = 0;
   localparam int TTD_TICK_SEL_W = 3;
   localparam int TTD_TICK_EN_BIT = 3;
   localparam int TTD_TONE_SEL_LSB = 5;
   localparam int TTD_TONE_SEL_W = 2;
   localparam int TTD_TONE_EN_BIT = 7;

   // configuration field layout
   localparam int TTD_CFG_SRC_BIT = 0;
   localparam int TTD_CFG_SLOW_BIT = 1;

   // event bits in status, clear and enable registers
   localparam int TTD_EVT_W = 2;
   localparam int TTD_EVT_TICK = 0;
   localparam int TTD_EVT_TONE = 1;

   // reset values
   localparam logic [2:0] TTD_TICK_SEL_RST = 3'h0;
   localparam logic [1:0] TTD_TONE_SEL_RST = 2'h0;
   localparam logic [TTD_EVT_W-1:0] TTD_EVT_RST = 2'h0;

   // divider widths
   localparam int TTD_FC_W = 23;
   localparam int TTD_FS_W = 13;

   // tap bit per tick code, high-frequency and low-frequency source
   localparam int TTD_FC_TICK_TAP [8] = '{22, 20, 15, 13, 12, 11, 10, 8};
   localparam int TTD_FS_TICK_TAP [8] = '{0, 12, 7, 5, 4, 3, 2, 0};
   // low-frequency code with no rate: tap held, no tick
   localparam logic [2:0] TTD_FS_TICK_NONE = 3'h0;

   // tap bit per tone code
   localparam int TTD_FC_TONE_TAP [4] = '{12, 11, 10, 9};
   localparam int TTD_FS_TONE_TAP [4] = '{4, 3, 2, 1};

endpackage

// File: verif/tb_tick_and_tone_divider.sv
/*
   Self-checking bench of the tick and tone divider over APB.
   Assumes source clocks far slower than the system clock so that
   the synchroniser sees every edge.
*/
`timescale 1ns/1ps
module tb_tick_and_tone_divider;
   localparam int FC_CYC = 6; // system cycles per fast source period
   localparam int FS_CYC = 10; // slowed low-frequency source, 40 ns
   localparam logic [7:0] CTRL = ttd_pkg::TTD_CTRL_OFS;
   localparam logic [7:0] CFG = ttd_pkg::TTD_CFG_OFS;
   localparam logic [7:0] STAT = ttd_pkg::TTD_STAT_OFS;
   localparam logic [7:0] CLR = ttd_pkg::TTD_CLR_OFS;
   localparam logic [7:0] IEN = ttd_pkg::TTD_IEN_OFS;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic fc_clk = 1'b0;
   logic fs_clk = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic irq;
   logic tone_n;
   int lo_len;
   int hi_len;
   int cyc = 0;
   int n_mismatch = 0;
   int check_count = 0;
   logic [31:0] lfsr = 32'h0000000D;
   logic [31:0] v;
   logic [33:0] exp_e;
   logic [33:0] exp_q [$]; // {is read, error, data}
   real fast_hz [8] = '{1.91, 7.63, 244.14, 976.56, 1953.13, 3906.25,
      7812.5, 31250.0};
   real slow_hz [8] = '{1.0, 4.0, 128.0, 512.0, 1024.0, 2048.0, 4096.0,
      16384.0};
   real tone_hz [4] = '{1024.0, 2048.0, 4096.0, 8192.0};

   ttd_top dut (.CLOCK_I(clk), .RST_N_I(rst_n), .FC_CLK_I(fc_clk),
      .FS_CLK_I(fs_clk), .PSEL_I(psel), .PENABLE_I(penable),
      .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
      .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
      .IRQ_O(irq), .TONE_N_O(tone_n));
   ttd_buzzer_model buzzer (.clk_i(clk), .tone_n_i(tone_n),
      .lo_len_o(lo_len), .hi_len_o(hi_len));

   // clocks; every source edge lands on a falling edge of the system clock
   initial
   begin
      forever #2 clk = ~clk;
   end
   initial
   begin
      forever #12 fc_clk = ~fc_clk;
   end
   initial
   begin
      // whole period must match FS_CYC, or long intervals drift off
      forever #20 fs_clk = ~fs_clk;
   end
   always @(posedge clk)
      cyc <= cyc + 1;

   function automatic logic [31:0] next_rand(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic stop_test();
      if (n_mismatch == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic check(input logic ok, input string msg);
      check_count++;
      if (ok !== 1'b1)
      begin
         n_mismatch++;
         $display("MISMATCH %0t %s", $time, msg);
      end
   endtask

   // one transfer; release waits an edge so the next setup is clean
   task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d, input logic err);
      int i;
      exp_q.push_back({~wr, err, d});
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      i = 0;
      do
      begin
         @(posedge clk);
         i++;
      end
      while (pready !== 1'b1 && i < 50);
      psel <= 1'b0;
      penable <= 1'b0;
      check(i < 50, "bus timeout");
      if (i >= 50)
         stop_test();
      @(posedge clk);
   endtask

   // completed transfers compared with the oldest note
   always @(posedge clk)
      if (psel && penable && pready === 1'b1 && exp_q.size() > 0)
      begin
         exp_e = exp_q.pop_front();
         check(pslverr === exp_e[32], "slave error flag");
         if (exp_e[33])
            check(prdata === exp_e[31:0], "read data");
      end

   task automatic wait_irq();
      int t;
      t = 0;
      while (irq !== 1'b1 && t < 90000)
      begin
         @(posedge clk);
         t++;
      end
      check(t < 90000, "interrupt timeout");
      if (t >= 90000)
         stop_test();
   endtask

   // second interval measured: the first may come early
   task automatic tick_period(input logic [2:0] code, input real src_hz,
      input real hz, input int src_cyc);
      int t0;
      int ex;
      ex = $rtoi(src_hz / hz + 0.5) * src_cyc;
      lfsr = next_rand(lfsr);
      repeat (lfsr[3:0]) @(posedge clk);
      apb(1'b1, CTRL, {28'h0, 1'b1, code}, 1'b0);
      wait_irq();
      t0 = cyc;
      apb(1'b1, CLR, 32'h1, 1'b0);
      wait_irq();
      check(cyc - t0 >= ex - 2 && cyc - t0 <= ex + 2, "tick period");
      apb(1'b1, CTRL, {28'h0, 1'b0, code}, 1'b0);
      apb(1'b1, CLR, 32'h1, 1'b0);
   endtask

   task automatic tone_check(input logic [1:0] code, input real src_hz,
      input real hz, input int src_cyc);
      int h;
      h = $rtoi(src_hz / hz / 2.0 + 0.5) * src_cyc;
      apb(1'b1, CTRL, {24'h0, 1'b1, code, 5'h0}, 1'b0);
      repeat (6 * h) @(posedge clk);
      check(lo_len >= h - 2 && lo_len <= h + 2, "tone low phase");
      check(hi_len >= h - 2 && hi_len <= h + 2, "tone high phase");
      apb(1'b1, CTRL, {24'h0, 1'b0, code, 5'h0}, 1'b0);
      repeat (3) @(posedge clk);
      check(tone_n === 1'b1, "tone idle level");
      // tone falls while enabled leave the tone event bit set
      apb(1'b0, STAT, 32'h2, 1'b0);
      apb(1'b1, CLR, 32'h2, 1'b0);
   endtask

   // main sequence
   initial
   begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      check(tone_n === 1'b1 && irq === 1'b0, "reset outputs");
      apb(1'b0, CTRL, 32'h0, 1'b0);
      apb(1'b0, STAT, 32'h0, 1'b0);
      lfsr = next_rand(lfsr);
      v = lfsr & 32'h000000EF;
      apb(1'b1, CTRL, v, 1'b0);
      apb(1'b0, CTRL, v, 1'b0);
      apb(1'b1, CTRL, v & 32'h00000067, 1'b0);
      apb(1'b1, CTRL, 32'h0, 1'b0);
      apb(1'b0, 8'h18, 32'h0, 1'b1);
      apb(1'b1, 8'h1C, lfsr, 1'b1);
      apb(1'b0, CLR, 32'h0, 1'b0);
      apb(1'b1, IEN, 32'h1, 1'b0);
      apb(1'b0, IEN, 32'h1, 1'b0);
      apb(1'b1, CLR, 32'h3, 1'b0);
      for (int c = 6; c < 8; c++)
         tick_period(3'(c), 16.0e6, fast_hz[c], FC_CYC);
      // odd codes through the source select, even through slow mode
      for (int c = 2; c < 8; c++)
      begin
         apb(1'b1, CFG, (c % 2) ? 32'h1 : 32'h2, 1'b0);
         tick_period(3'(c), 32768.0, slow_hz[c], FS_CYC);
      end
      // masked event still sets status, line stays low
      apb(1'b1, CFG, 32'h0, 1'b0);
      apb(1'b1, IEN, 32'h0, 1'b0);
      apb(1'b1, CTRL, 32'hF, 1'b0);
      repeat (7000) @(posedge clk);
      check(irq === 1'b0, "masked interrupt");
      apb(1'b0, STAT, 32'h1, 1'b0);
      apb(1'b1, CTRL, 32'h7, 1'b0);
      apb(1'b1, CLR, 32'h1, 1'b0);
      apb(1'b0, STAT, 32'h0, 1'b0);
      tone_check(2'h3, 16.0e6, 15625.0, FC_CYC);
      apb(1'b1, CFG, 32'h1, 1'b0);
      for (int c = 0; c < 4; c++)
         tone_check(2'(c), 32768.0, tone_hz[c], FS_CYC);
      stop_test();
   end
endmodule

// File: verif/ttd_buzzer_model.sv
/*
   Piezo buzzer load on the tone pin: measures each low and high phase
   of the drive in system cycles.
   Assumes the pin is sampled on the system clock.
*/
`timescale 1ns/1ps
module ttd_buzzer_model (
   input wire logic clk_i,
   input wire logic tone_n_i,
   output int lo_len_o,
   output int hi_len_o
);
   int run_len = 0;
   logic last_lvl = 1'b1;

   // a phase ends when the pin toggles; its length is kept
   always @(posedge clk_i)
   begin
      if (tone_n_i !== last_lvl)
      begin
         if (last_lvl === 1'b0)
            lo_len_o <= run_len;
         else
            hi_len_o <= run_len;
         run_len <= 1;
      end
      else
         run_len <= run_len + 1;
      last_lvl <= tone_n_i;
   end
endmodule
